/* File: pkg/spi_port_map.svh */
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH

// Datagram layout
`define SPI_FRAME_BITS 40
`define SPI_DATA_BITS 32
`define SPI_ADDR_BITS 7
`define SPI_WR_BIT 39
`define SPI_STAT_HI 39
`define SPI_STAT_LO 32
`define SPI_WR_FLAG 8'h80

// Status byte field positions
`define STAT_RSVD 7
`define STAT_STOP_L2 6
`define STAT_STOP_L1 5
`define STAT_VEL2 4
`define STAT_VEL1 3
`define STAT_DRV_ERR2 2
`define STAT_DRV_ERR1 1
`define STAT_RESET 0

// Source bits in the ramp and global condition words
`define RAMP_STOP_L_BIT 0
`define RAMP_VEL_BIT 8
`define GLOB_RESET_BIT 0
`define GLOB_DRV1_BIT 1
`define GLOB_DRV2_BIT 2

// Reset values
`define STATUS_RESET 8'h00
`define REPLY_RESET 32'h0000_0000

// Timing
`define SYS_CLK_NS 8
`define SCK_HALF_NS 40
`define SCK_HALF_CYC ((`SCK_HALF_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define CS_GAP_NS 200
`define CS_GAP_CYC ((`CS_GAP_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define HOST_CNT_W 8

`endif

/* File: pkg/spi_port_pkg.sv */
package spi_port_pkg;

  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [31:0] data;
  } datagram_s;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_LEAD = 5'h02,
    H_LOW = 5'h04,
    H_HIGH = 5'h08,
    H_GAP = 5'h10
  } host_state_e;

endpackage : spi_port_pkg

/* File: pkg/spi_link_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface spi_link_if;
  logic sck;
  logic chip_select_n;
  logic sdi;
  logic sdo;

  modport device (
    input sck,
    input chip_select_n,
    input sdi,
    output sdo
  );

  modport host (
    output sck,
    output chip_select_n,
    output sdi,
    input sdo
  );
endinterface : spi_link_if

`default_nettype wire

/* File: rtl/pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter logic IDLE = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Pin side
  input wire logic pin_in,
  // Filtered level and its edges
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s1 <= IDLE;
      s2 <= IDLE;
      s3 <= IDLE;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts only once the last two stages agree
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      level <= IDLE;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= (s2 == s3) && s3 && !level;
      fall <= (s2 == s3) && !s3 && level;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule : pin_sync

`default_nettype wire

/* File: rtl/spi_register_access_port.sv */
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "spi_port_map.svh"

module spi_register_access_port (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Serial link
  spi_link_if.device link,
  // Register set access
  output logic [6:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Status sources
  input wire logic [8:0] axis1_ramp_condition,
  input wire logic [8:0] axis2_ramp_condition,
  input wire logic [2:0] global_condition_register,
  // Frame results
  output logic frame_taken,
  output logic frame_short
);
  logic sck_rise;
  logic sck_fall;
  logic cs_lvl;
  logic cs_rise;
  logic cs_fall;
  logic sdi_lvl;
  logic [39:0] shreg;
  logic [5:0] bit_cnt;
  logic frame_full;
  spi_port_pkg::datagram_s cmd;
  logic capture;
  logic [7:0] status;
  logic [31:0] reply_data;
  logic [7:0] fresh_status;

  // Clock idles high, select idles high, data idles low
  pin_sync #(.IDLE(1'b1)) u_sck (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin_in(link.sck),
    .level(),
    .rise(sck_rise),
    .fall(sck_fall)
  );

  pin_sync #(.IDLE(1'b1)) u_cs (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin_in(link.chip_select_n),
    .level(cs_lvl),
    .rise(cs_rise),
    .fall(cs_fall)
  );

  pin_sync #(.IDLE(1'b0)) u_sdi (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin_in(link.sdi),
    .level(sdi_lvl),
    .rise(),
    .fall()
  );

  // Status byte as it stands now
  always_comb begin
    fresh_status = 8'h00;
    fresh_status[`STAT_RSVD] = 1'b0;
    fresh_status[`STAT_STOP_L2] =
      axis2_ramp_condition[`RAMP_STOP_L_BIT];
    fresh_status[`STAT_STOP_L1] =
      axis1_ramp_condition[`RAMP_STOP_L_BIT];
    fresh_status[`STAT_VEL2] = axis2_ramp_condition[`RAMP_VEL_BIT];
    fresh_status[`STAT_VEL1] = axis1_ramp_condition[`RAMP_VEL_BIT];
    fresh_status[`STAT_DRV_ERR2] =
      global_condition_register[`GLOB_DRV2_BIT];
    fresh_status[`STAT_DRV_ERR1] =
      global_condition_register[`GLOB_DRV1_BIT];
    fresh_status[`STAT_RESET] =
      global_condition_register[`GLOB_RESET_BIT];
  end

  // Shift register: loaded with the reply, filled from the master.
  // After 40 rising edges the first bit received reaches the top,
  // so excess bits leave on the output 40 clocks late.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      shreg <= 40'h00_0000_0000;
    end else if (cs_fall) begin
      shreg <= {status, reply_data};
    end else if (sck_rise && !cs_lvl) begin
      shreg <= {shreg[38:0], sdi_lvl};
    end
  end

  // Counts rising edges up to a full datagram, then saturates
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bit_cnt <= 6'h00;
    end else if (cs_fall) begin
      bit_cnt <= 6'h00;
    end else if (sck_rise && !cs_lvl && !frame_full) begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  assign frame_full = (bit_cnt == 6'(`SPI_FRAME_BITS));

  // Output bit changes on the select's falling edge and after each clock falling edge inside a frame
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      link.sdo <= 1'b0;
    end else if (cs_fall) begin
      link.sdo <= status[7];
    end else if (sck_fall && !cs_lvl) begin
      link.sdo <= shreg[`SPI_WR_BIT];
    end
  end

  // Command latch on the select's rising edge. A short frame is
  // dropped whole: its bits cannot form a datagram.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cmd <= '0;
      frame_taken <= 1'b0;
      frame_short <= 1'b0;
    end else begin
      frame_taken <= cs_rise && frame_full;
      frame_short <= cs_rise && !frame_full;
      if (cs_rise && frame_full) begin
        cmd <= spi_port_pkg::datagram_s'(shreg);
      end
    end
  end

  // Register set strobes, one cycle after the command latch
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= 7'h00;
      reg_wdata <= 32'h0000_0000;
    end else begin
      reg_wr <= frame_taken && cmd.wr;
      reg_rd <= frame_taken && !cmd.wr;
      if (frame_taken) begin
        reg_addr <= cmd.addr;
        reg_wdata <= cmd.data;
      end
    end
  end

  // Read data arrive the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      capture <= 1'b0;
    end else begin
      capture <= reg_wr || reg_rd;
    end
  end

  // Status is taken at the strobe itself: the register set clears the
  // global flags on that same edge, so a read still reports them
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      status <= `STATUS_RESET;
    end else if (reg_wr || reg_rd) begin
      status <= fresh_status;
    end
  end

  // Reply data for the next frame
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      reply_data <= `REPLY_RESET;
    end else if (capture) begin
      if (cmd.wr) begin
        reply_data <= cmd.data;
      end else begin
        reply_data <= reg_rdata;
      end
    end
  end
endmodule : spi_register_access_port

`default_nettype wire

/* File: rtl/spi_host_master.sv */
`timescale 1ns/1ns
`default_nettype none
`include "spi_port_map.svh"

module spi_host_master (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Serial link
  spi_link_if.host link,
  // Request
  input wire logic start,
  input wire logic wr,
  input wire logic [6:0] addr,
  input wire logic [31:0] wdata,
  // Answer
  output logic busy,
  output logic done,
  output logic [7:0] status,
  output logic [31:0] rdata
);
  spi_port_pkg::host_state_e state;
  logic [7:0] tick;
  logic [5:0] bits_left;
  logic [39:0] tx;
  logic [39:0] rx;
  logic sdo_lvl;
  logic half_done;

  // Device output comes from another clock as far as this end knows
  pin_sync #(.IDLE(1'b0)) u_sdo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin_in(link.sdo),
    .level(sdo_lvl),
    .rise(),
    .fall()
  );

  assign half_done = (tick == 8'(`SCK_HALF_CYC - 1));
  assign busy = (state != spi_port_pkg::H_IDLE);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state <= spi_port_pkg::H_IDLE;
      tick <= 8'h00;
      bits_left <= 6'h00;
    end else begin
      tick <= tick + 8'h01;
      unique case (state)
        spi_port_pkg::H_IDLE: begin
          tick <= 8'h00;
          if (start) begin
            state <= spi_port_pkg::H_LEAD;
            bits_left <= 6'(`SPI_FRAME_BITS);
          end
        end
        spi_port_pkg::H_LEAD: begin
          if (half_done) begin
            state <= spi_port_pkg::H_LOW;
            tick <= 8'h00;
          end
        end
        spi_port_pkg::H_LOW: begin
          if (half_done) begin
            state <= spi_port_pkg::H_HIGH;
            tick <= 8'h00;
            bits_left <= bits_left - 6'h01;
          end
        end
        spi_port_pkg::H_HIGH: begin
          if (half_done) begin
            tick <= 8'h00;
            state <= (bits_left == 6'h00) ? spi_port_pkg::H_GAP
                                          : spi_port_pkg::H_LOW;
          end
        end
        spi_port_pkg::H_GAP: begin
          // Gives the device time to execute before the next frame
          if (tick == 8'(`CS_GAP_CYC - 1)) begin
            state <= spi_port_pkg::H_IDLE;
          end
        end
      endcase
    end
  end

  // Pins: clock idles high, data change on the falling edge
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      link.sck <= 1'b1;
      link.chip_select_n <= 1'b1;
      link.sdi <= 1'b0;
      tx <= 40'h00_0000_0000;
    end else begin
      if (state == spi_port_pkg::H_IDLE && start) begin
        link.chip_select_n <= 1'b0;
        link.sdi <= wr;
        tx <= {wr, addr, wdata} << 1;
      end
      if (state == spi_port_pkg::H_LEAD && half_done) begin
        link.sck <= 1'b0;
      end
      if (state == spi_port_pkg::H_LOW && half_done) begin
        link.sck <= 1'b1;
      end
      if (state == spi_port_pkg::H_HIGH && half_done) begin
        if (bits_left == 6'h00) begin
          link.chip_select_n <= 1'b1;
        end else begin
          link.sck <= 1'b0;
          link.sdi <= tx[39];
          tx <= tx << 1;
        end
      end
    end
  end

  // Sample late in the high phase, after the synchroniser delay
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rx <= 40'h00_0000_0000;
      done <= 1'b0;
      status <= 8'h00;
      rdata <= 32'h0000_0000;
    end else begin
      done <= 1'b0;
      if (state == spi_port_pkg::H_HIGH && half_done) begin
        rx <= {rx[38:0], sdo_lvl};
      end
      if (state == spi_port_pkg::H_GAP && tick == 8'h00) begin
        status <= rx[`SPI_STAT_HI:`SPI_STAT_LO];
        rdata <= rx[31:0];
        done <= 1'b1;
      end
    end
  end
endmodule : spi_host_master

`default_nettype wire

/* File: verification/spi_link_chk.sv */
`timescale 1ns/1ns
`default_nettype none

module spi_link_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Link
  input wire logic sck,
  input wire logic chip_select_n,
  input wire logic sdi,
  input wire logic sdo
);
  logic sck_q;
  logic [7:0] rises;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sck_q <= 1'b1;
    end else begin
      sck_q <= sck;
    end
  end

  // Rising link clock edges seen in the current frame
  always_ff @(posedge sys_clk) begin
    if (!nrst || chip_select_n) begin
      rises <= 8'h00;
    end else if (sck && !sck_q) begin
      rises <= rises + 8'h01;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Synchroniser plus filter need five cycles in each phase
  sequence s_high_phase;
    sck [*5];
  endsequence
  sequence s_low_phase;
    !sck [*5];
  endsequence

  a_sck_idle_high: assert property (chip_select_n |-> sck)
    else $error("link clock low outside a frame");
  a_select_edges: assert property (
    $changed(chip_select_n) |-> sck && $past(sck))
    else $error("select moved while link clock low");
  a_high_phase: assert property ($rose(sck) |-> s_high_phase)
    else $error("link clock high phase too short");
  a_low_phase: assert property ($fell(sck) |-> s_low_phase)
    else $error("link clock low phase too short");
  a_sdi_setup: assert property (
    !chip_select_n && $past(!chip_select_n) && sck && $past(sck)
    |-> $stable(sdi))
    else $error("serial input moved in high phase");
  a_forty_rises: assert property (
    $rose(chip_select_n) |-> rises == 8'h28)
    else $error("frame without exactly forty clocks");
  a_gap_hold: assert property (
    $rose(chip_select_n) |-> chip_select_n [*8])
    else $error("select high time too short");
  a_sdo_quiet: assert property ($rose(sck) |=> $stable(sdo) [*3])
    else $error("serial output moved in high phase");
endmodule : spi_link_chk

`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic sys_clk;
  logic nrst;
  logic start;
  logic wr;
  logic [6:0] addr;
  logic [31:0] wdata;
  logic busy;
  logic done;
  logic [7:0] status;
  logic [31:0] rdata;
  logic [6:0] reg_addr;
  logic [6:0] reg_addr2;
  logic [31:0] reg_wdata;
  logic [31:0] reg_wdata2;
  logic [31:0] reg_rdata = 32'h0000_0000;
  logic reg_wr;
  logic reg_rd;
  logic reg_wr2;
  logic short2;
  logic [8:0] ramp1;
  logic [8:0] ramp2;
  logic [2:0] glob = 3'h0;
  logic [2:0] glob_src;
  logic [2:0] glob_src_q = 3'h0;
  logic [31:0] regs [0:127];
  logic [7:0] st;
  logic [7:0] s;
  logic [31:0] rd;
  logic [47:0] got2;
  int n_errors = 0;
  int checked = 0;
  int n_wr2 = 0;
  int n_short2 = 0;

  spi_link_if lnk ();
  spi_link_if lnk2 ();

  spi_host_master i_spi_host_master (.sys_clk(sys_clk), .nrst(nrst),
    .link(lnk), .start(start), .wr(wr), .addr(addr), .wdata(wdata),
    .busy(busy), .done(done), .status(status), .rdata(rdata));
  spi_register_access_port i_spi_register_access_port (.sys_clk(sys_clk),
    .nrst(nrst), .link(lnk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .axis1_ramp_condition(ramp1), .axis2_ramp_condition(ramp2),
    .global_condition_register(glob), .frame_taken(), .frame_short());
  // Second port faces the bench's own rule-breaking driver
  spi_register_access_port i_spi_register_access_port2 (.sys_clk(sys_clk),
    .nrst(nrst), .link(lnk2), .reg_addr(reg_addr2), .reg_wdata(reg_wdata2),
    .reg_wr(reg_wr2), .reg_rd(), .reg_rdata(reg_rdata),
    .axis1_ramp_condition(ramp1), .axis2_ramp_condition(ramp2),
    .global_condition_register(glob), .frame_taken(), .frame_short(short2));
  spi_link_chk i_spi_link_chk (.sys_clk(sys_clk), .nrst(nrst),
    .sck(lnk.sck), .chip_select_n(lnk.chip_select_n), .sdi(lnk.sdi),
    .sdo(lnk.sdo));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Register file; address 01 is the self-clearing global word
  always @(posedge sys_clk) begin
    if (reg_wr) regs[reg_addr] <= reg_wdata;
    if (reg_rd) reg_rdata <= (reg_addr == 7'h01) ? {29'h0, glob}
                                                 : regs[reg_addr];
    // Global word follows its source until a read clears it
    glob_src_q <= glob_src;
    if (reg_rd && reg_addr == 7'h01) begin
      glob <= 3'h0;
    end else if (glob_src != glob_src_q) begin
      glob <= glob_src;
    end
    if (reg_wr2) n_wr2 <= n_wr2 + 1;
    if (short2) n_short2 <= n_short2 + 1;
  end

  task automatic chk_word(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_stat(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_stat

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic xfer(input logic w, input logic [6:0] a,
                      input logic [31:0] d);
    int k;
    k = 0;
    start <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    start <= 1'b0;
    while (done !== 1'b1 && k < 3000) begin
      @(posedge sys_clk);
      k++;
    end
    st = status;
    rd = rdata;
    while (busy !== 1'b0 && k < 3000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 3000) begin
      n_errors++;
      give_verdict();
    end
  endtask : xfer

  // Sends the low n bits of v, sampling the reply like the host does
  task automatic shift2(input logic [47:0] v, input int n);
    lnk2.chip_select_n <= 1'b0;
    lnk2.sdi <= v[n-1];
    repeat (5) @(posedge sys_clk);
    for (int b = n - 1; b >= 0; b--) begin
      lnk2.sck <= 1'b0;
      lnk2.sdi <= v[b];
      repeat (5) @(posedge sys_clk);
      lnk2.sck <= 1'b1;
      repeat (5) @(posedge sys_clk);
      got2 = {got2[46:0], lnk2.sdo};
    end
    lnk2.chip_select_n <= 1'b1;
    lnk2.sdi <= ~v[0];
    repeat (25) @(posedge sys_clk);
  endtask : shift2

  initial begin
    nrst = 1'b0;
    start = 1'b0;
    wr = 1'b0;
    addr = 7'h00;
    wdata = 32'h0;
    ramp1 = 9'h0;
    ramp2 = 9'h0;
    glob_src = 3'h0;
    lnk2.sck = 1'b1;
    lnk2.chip_select_n = 1'b1;
    lnk2.sdi = 1'b0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);

    xfer(1'b1, 7'h27, 32'h00ab_cdef);
    chk_word("first reply", 32'h0, rd);
    xfer(1'b0, 7'h27, 32'hffff_ffff);
    chk_word("write echo", 32'h00ab_cdef, rd);
    xfer(1'b1, 7'h10, 32'h8000_0001);
    chk_word("read reply", 32'h00ab_cdef, rd);
    chk_word("dummy kept out", 32'h00ab_cdef, regs[7'h27]);
    xfer(1'b0, 7'h10, 32'h5555_aaaa);
    chk_word("second echo", 32'h8000_0001, rd);
    xfer(1'b0, 7'h11, 32'h0);
    chk_word("read back", 32'h8000_0001, rd);
    $display("test pipeline done");

    // Sources drop before the second access, so only a latch shows them
    for (int i = 0; i <= 7; i++) begin
      s = (i == 7) ? 8'hff : 8'h01 << i;
      ramp1 <= {s[3], 7'h55, s[5]};
      ramp2 <= {s[4], 7'h2a, s[6]};
      glob_src <= s[2:0];
      xfer(1'b0, 7'h27, 32'h0);
      ramp1 <= 9'h0;
      ramp2 <= 9'h0;
      glob_src <= 3'h0;
      xfer(1'b0, 7'h27, 32'h0);
      chk_stat("status flags", s & 8'h7f, st);
    end
    $display("test status done");

    glob_src <= 3'h7;
    xfer(1'b0, 7'h01, 32'h0);
    xfer(1'b0, 7'h27, 32'h0);
    chk_stat("flags before clear", 8'h07, st);
    chk_word("global word", 32'h7, rd);
    xfer(1'b0, 7'h27, 32'h0);
    chk_stat("flags after clear", 8'h00, st);
    $display("test clear done");

    shift2({9'h1, 7'h35, 32'h1234_abcd}, 39);
    chk_word("short frames", 32'h1, 32'(n_short2));
    chk_word("short writes", 32'h0, 32'(n_wr2));
    shift2({8'hc3, 1'b1, 7'h35, 32'h1234_abcd}, 48);
    chk_word("long writes", 32'h1, 32'(n_wr2));
    chk_word("long address", 32'h35, {25'h0, reg_addr2});
    chk_word("long data", 32'h1234_abcd, reg_wdata2);
    chk_word("reply data", 32'h0, got2[39:8]);
    chk_stat("chained bits", 8'hc3, got2[7:0]);
    $display("test chain done");
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
